// *** verilog/ctu_pkg.sv ***
// constants for the charge timer edge control block
// assumes one 32-bit control word at byte offset 0 of a small Avalon-MM window
package ctu_pkg;
    localparam int          CTU_ADDR_W     = 4;
    localparam logic [3:0]  CTU_CTRL_ADDR  = 4'h0;
    localparam logic [31:0] CTU_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTU_WR_MASK    = 32'hFFFC_BFFF;
    localparam int CTU_E1_MODE   = 31;
    localparam int CTU_E1_POL    = 30;
    localparam int CTU_E1_SEL_HI = 29;
    localparam int CTU_E1_SEL_LO = 26;
    localparam int CTU_E2_SEEN   = 25;
    localparam int CTU_E1_SEEN   = 24;
    localparam int CTU_E2_MODE   = 23;
    localparam int CTU_E2_POL    = 22;
    localparam int CTU_E2_SEL_HI = 21;
    localparam int CTU_E2_SEL_LO = 18;
    localparam int CTU_ON        = 15;
    localparam int CTU_IDLE_STOP = 13;
    localparam int CTU_DELAY_GEN = 12;
    localparam int CTU_EDGE_GATE = 11;
    localparam int CTU_EDGE_ORD  = 10;
    localparam int CTU_SRC_GND   = 9;
    localparam int CTU_TRIG_EN   = 8;
    localparam int CTU_TRIM_HI   = 7;
    localparam int CTU_TRIM_LO   = 2;
    localparam int CTU_RANGE_HI  = 1;
    localparam int CTU_RANGE_LO  = 0;
    localparam int CTU_PIN_N     = 13;
    // source select codes
    localparam logic [3:0] CTU_SEL_TICK    = 4'h0;
    localparam logic [3:0] CTU_SEL_CMPEV   = 4'h1;
    localparam logic [3:0] CTU_SEL_PIN2    = 4'h2;
    localparam logic [3:0] CTU_SEL_PIN1    = 4'h3;
    localparam logic [3:0] CTU_SEL1_CAP1   = 4'hA;
    localparam logic [3:0] CTU_SEL2_CAP1   = 4'h9;
    localparam logic [3:0] CTU_SEL2_BUSCLK = 4'hC;
    localparam logic [3:0] CTU_SEL_CMP1    = 4'hD;
    localparam logic [3:0] CTU_SEL_CMP2    = 4'hE;
    localparam logic [3:0] CTU_SEL_RSVD    = 4'hF;
    localparam logic [1:0] CTU_RANGE_RESET = 2'h0;
    localparam logic [5:0] CTU_TRIM_RESET  = 6'h00;
endpackage

// *** verilog/ctu_charge_timer.sv ***
// digital control of the charge timer unit: edge select, edge flags, current source control
// assumes an Avalon-MM master on clock, async pins and comparator results from outside
`timescale 1ns/1ns
module ctu_charge_timer
    import ctu_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic [CTU_ADDR_W-1:0] address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire logic                  idle_mode,
    input  wire logic                  first_tick_event,
    input  wire logic                  compare1_event,
    input  wire logic                  capture1_event,
    input  wire logic                  capture2_event,
    input  wire logic                  capture3_event,
    input  wire logic [CTU_PIN_N-1:0]  edge_input_pin,
    input  wire logic                  cmp1_result,
    input  wire logic                  cmp2_result,
    output logic                       current_source_on,
    output logic                       source_ground,
    output logic                       trigger_out,
    output logic                       delay_gen_active,
    output logic      [5:0]            current_trim,
    output logic      [1:0]            current_range
);

    logic [31:0]          ctrl;
    logic [CTU_PIN_N+1:0] async_meta;
    logic [CTU_PIN_N+1:0] async_sync;
    logic                 busclk_toggle;
    logic                 src1;
    logic                 src2;
    logic                 src1_prev;
    logic                 src2_prev;
    logic                 active;
    logic                 e1_hit;
    logic                 e2_hit;
    logic                 e1_trig;
    logic                 e2_trig;
    logic                 wr_take;
    logic [31:0]          next_ctrl;
    logic [31:0]          be_mask;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for pins and comparator results
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            async_meta <= '0;
            async_sync <= '0;
        end else begin
            async_meta <= {cmp2_result, cmp1_result, edge_input_pin};
            async_sync <= async_meta;
        end
    end

    // bus clock as a source: a flop that toggles on every rising clock edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busclk_toggle <= 1'b0;
        end else begin
            busclk_toggle <= ~busclk_toggle;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source multiplexers
    always_comb begin
        src1 = 1'b0;
        unique case (ctrl[CTU_E1_SEL_HI:CTU_E1_SEL_LO])
            CTU_SEL_TICK:       src1 = first_tick_event;
            CTU_SEL_CMPEV:      src1 = compare1_event;
            CTU_SEL_PIN2:       src1 = async_sync[1];
            CTU_SEL_PIN1:       src1 = async_sync[0];
            4'h4, 4'h5, 4'h6,
            4'h7, 4'h8, 4'h9:   src1 = async_sync[ctrl[CTU_E1_SEL_HI:CTU_E1_SEL_LO] - 4'h2];
            CTU_SEL1_CAP1:      src1 = capture1_event;
            4'hB:               src1 = capture2_event;
            4'hC:               src1 = capture3_event;
            CTU_SEL_CMP1:       src1 = async_sync[CTU_PIN_N];
            CTU_SEL_CMP2:       src1 = async_sync[CTU_PIN_N+1];
            CTU_SEL_RSVD:       src1 = 1'b0;
        endcase
    end

    always_comb begin
        src2 = 1'b0;
        unique case (ctrl[CTU_E2_SEL_HI:CTU_E2_SEL_LO])
            CTU_SEL_TICK:       src2 = first_tick_event;
            CTU_SEL_CMPEV:      src2 = compare1_event;
            CTU_SEL_PIN2:       src2 = async_sync[1];
            CTU_SEL_PIN1:       src2 = async_sync[0];
            4'h4, 4'h5, 4'h6,
            4'h7, 4'h8:         src2 = async_sync[ctrl[CTU_E2_SEL_HI:CTU_E2_SEL_LO] + 4'h4];
            CTU_SEL2_CAP1:      src2 = capture1_event;
            4'hA:               src2 = capture2_event;
            4'hB:               src2 = capture3_event;
            CTU_SEL2_BUSCLK:    src2 = busclk_toggle;
            CTU_SEL_CMP1:       src2 = async_sync[CTU_PIN_N];
            CTU_SEL_CMP2:       src2 = async_sync[CTU_PIN_N+1];
            CTU_SEL_RSVD:       src2 = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            src1_prev <= 1'b0;
            src2_prev <= 1'b0;
        end else begin
            src1_prev <= src1;
            src2_prev <= src2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge qualification; a select change may look like one spurious edge
    assign active = ctrl[CTU_ON] && !(ctrl[CTU_IDLE_STOP] && idle_mode);

    always_comb begin
        if (ctrl[CTU_E1_MODE]) begin
            e1_trig = ctrl[CTU_E1_POL] ? (src1 && !src1_prev) : (!src1 && src1_prev);
        end else begin
            e1_trig = (src1 == ctrl[CTU_E1_POL]);
        end
        if (ctrl[CTU_E2_MODE]) begin
            e2_trig = ctrl[CTU_E2_POL] ? (src2 && !src2_prev) : (!src2 && src2_prev);
        end else begin
            e2_trig = (src2 == ctrl[CTU_E2_POL]);
        end
    end

    assign e1_hit = active && ctrl[CTU_EDGE_GATE] && e1_trig;
    assign e2_hit = active && ctrl[CTU_EDGE_GATE] && e2_trig
                    && (!ctrl[CTU_EDGE_ORD] || ctrl[CTU_E1_SEEN]);

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait state, so every access completes in two cycles
    assign wr_take = write && !waitrequest && (address == CTU_CTRL_ADDR);
    assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(waitrequest && (read || write));
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= (address == CTU_CTRL_ADDR) ? ctrl : 32'h0000_0000;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        if (wr_take) begin
            next_ctrl = (ctrl & ~(be_mask & CTU_WR_MASK))
                      | (writedata & be_mask & CTU_WR_MASK);
        end
        // a hardware edge wins over a software clear in the same cycle
        if (e1_hit) begin
            next_ctrl[CTU_E1_SEEN] = 1'b1;
        end
        if (e2_hit) begin
            next_ctrl[CTU_E2_SEEN] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl <= CTU_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog side controls, all registered
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            current_source_on <= 1'b0;
            source_ground     <= 1'b0;
            trigger_out       <= 1'b0;
            delay_gen_active  <= 1'b0;
        end else begin
            current_source_on <= active && (ctrl[CTU_E1_SEEN] ^ ctrl[CTU_E2_SEEN]);
            source_ground     <= ctrl[CTU_SRC_GND];
            trigger_out       <= active && ctrl[CTU_TRIG_EN] && ctrl[CTU_E2_SEEN];
            delay_gen_active  <= active && ctrl[CTU_DELAY_GEN];
        end
    end

    // trim is signed about nominal; range code 00 is the largest current
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            current_trim  <= CTU_TRIM_RESET;
            current_range <= CTU_RANGE_RESET;
        end else begin
            current_trim  <= ctrl[CTU_TRIM_HI:CTU_TRIM_LO];
            current_range <= ctrl[CTU_RANGE_HI:CTU_RANGE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_unimpl_bits_zero: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl & ~CTU_WR_MASK) == 32'h0000_0000)
        else $error("unimplemented control bits not zero");

    a_edge1_rise: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_EDGE_GATE] && ctrl[CTU_E1_MODE] && ctrl[CTU_E1_POL]
         && src1 && !src1_prev) |=> ctrl[CTU_E1_SEEN])
        else $error("rising edge 1 did not set edge1_seen");

    a_edge1_fall_only: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl[CTU_E1_MODE] && !ctrl[CTU_E1_POL] && src1 && !src1_prev) |-> !e1_trig)
        else $error("falling polarity fired on rising edge");

    a_rsvd_sel_quiet: assert property (@(posedge clock) disable iff (!nrst)
        ctrl[CTU_E1_SEL_HI:CTU_E1_SEL_LO] == CTU_SEL_RSVD |-> !src1)
        else $error("reserved source select produced a source");

    a_busclk_src: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl[CTU_E2_SEL_HI:CTU_E2_SEL_LO] == CTU_SEL2_BUSCLK)
        ##1 (ctrl[CTU_E2_SEL_HI:CTU_E2_SEL_LO] == CTU_SEL2_BUSCLK) |-> src2 != $past(src2))
        else $error("bus clock source did not toggle");

    a_edge2_level: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_EDGE_GATE] && !ctrl[CTU_E2_MODE] && !ctrl[CTU_EDGE_ORD]
         && src2 == ctrl[CTU_E2_POL]) |=> ctrl[CTU_E2_SEEN])
        else $error("level on edge 2 did not set edge2_seen");

    a_seen_sticky: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl[CTU_E1_SEEN] && !wr_take) |=> ctrl[CTU_E1_SEEN])
        else $error("edge1_seen lost without a write");

    a_set_beats_clear: assert property (@(posedge clock) disable iff (!nrst)
        e2_hit |=> ctrl[CTU_E2_SEEN])
        else $error("edge 2 lost against a clear");

    a_off_no_edges: assert property (@(posedge clock) disable iff (!nrst)
        (!ctrl[CTU_ON] && !wr_take) |=> $stable(ctrl[CTU_E2_SEEN:CTU_E1_SEEN]))
        else $error("edge accepted while unit disabled");

    a_idle_stop: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl[CTU_IDLE_STOP] && idle_mode) |=> !current_source_on && !delay_gen_active)
        else $error("unit active in idle with idle_stop set");

    a_gate_blocks: assert property (@(posedge clock) disable iff (!nrst)
        (!ctrl[CTU_EDGE_GATE] && !wr_take) |=> $stable(ctrl[CTU_E2_SEEN:CTU_E1_SEEN]))
        else $error("edge passed while gate closed");

    a_edge_order: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl[CTU_EDGE_ORD] && !ctrl[CTU_E1_SEEN] && !wr_take) |=> !$rose(ctrl[CTU_E2_SEEN]))
        else $error("edge 2 taken before edge 1");

    a_trigger_gate: assert property (@(posedge clock) disable iff (!nrst)
        !ctrl[CTU_TRIG_EN] |=> !trigger_out)
        else $error("trigger output driven while disabled");

    a_range_follow: assert property (@(posedge clock) disable iff (!nrst)
        wr_take && byteenable[0] |=> ##1 current_range == $past(writedata[1:0], 2))
        else $error("current range did not follow write");

    a_source_one_flag: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_E1_SEEN] && ctrl[CTU_E2_SEEN]) |=> !current_source_on)
        else $error("current source on with both flags set");

    a_source_on_one: assert property (@(posedge clock) disable iff (!nrst)
        (active && (ctrl[CTU_E1_SEEN] ^ ctrl[CTU_E2_SEEN])) |=> current_source_on)
        else $error("current source off with exactly one flag set");

    a_unmapped_read_zero: assert property (@(posedge clock) disable iff (!nrst)
        (read && waitrequest && address != CTU_CTRL_ADDR) |=> readdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    a_trigger_follow: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_TRIG_EN] && ctrl[CTU_E2_SEEN]) |=> trigger_out)
        else $error("trigger output not driven when enabled");

    a_ground_follow: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> source_ground == $past(ctrl[CTU_SRC_GND]))
        else $error("source ground output does not follow control");

    a_delay_gen_off: assert property (@(posedge clock) disable iff (!nrst)
        !ctrl[CTU_DELAY_GEN] |=> !delay_gen_active)
        else $error("delay generation active while disabled");

    a_trim_follow: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> current_trim == $past(ctrl[CTU_TRIM_HI:CTU_TRIM_LO]))
        else $error("current trim does not follow control");

    a_edge2_rise: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_EDGE_GATE] && ctrl[CTU_E2_MODE] && ctrl[CTU_E2_POL]
         && src2 && !src2_prev && (!ctrl[CTU_EDGE_ORD] || ctrl[CTU_E1_SEEN])) |=> ctrl[CTU_E2_SEEN])
        else $error("rising edge 2 did not set edge2_seen");

    a_edge1_fall: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_EDGE_GATE] && ctrl[CTU_E1_MODE] && !ctrl[CTU_E1_POL]
         && !src1 && src1_prev) |=> ctrl[CTU_E1_SEEN])
        else $error("falling edge 1 did not set edge1_seen");

    a_edge1_level: assert property (@(posedge clock) disable iff (!nrst)
        (active && ctrl[CTU_EDGE_GATE] && !ctrl[CTU_E1_MODE]
         && src1 == ctrl[CTU_E1_POL]) |=> ctrl[CTU_E1_SEEN])
        else $error("level on edge 1 did not set edge1_seen");

    a_inactive_outs_off: assert property (@(posedge clock) disable iff (!nrst)
        !active |=> !current_source_on && !trigger_out && !delay_gen_active)
        else $error("analog controls driven while unit inactive");

endmodule

// *** verif/ctu_analog_model.sv ***
// far side model: charge node, comparators, edge pins
// assumes the bench sets pin and comparator 1 levels
`timescale 1ns/1ns
module ctu_analog_model
    import ctu_pkg::*;
#(
    parameter int THRESH = 24
)(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 current_source_on,
    input  wire logic                 source_ground,
    input  wire logic [1:0]           current_range,
    input  wire logic [CTU_PIN_N-1:0] pin_drive,
    input  wire logic                 cmp1_drive,
    output logic      [CTU_PIN_N-1:0] edge_input_pin,
    output logic                      cmp1_result,
    output logic                      cmp2_result
);
    logic [9:0] charge;
    // steps scaled down from real current ratios to keep runs short
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            charge <= 10'h000;
        end else if (source_ground) begin
            charge <= 10'h000;
        end else if (current_source_on && charge < 10'h300) begin
            charge <= charge + ((current_range == 2'h0) ? 10'h008 : (10'h001 << (current_range - 2'h1)));
        end
    end
    assign cmp2_result    = (charge >= 10'(THRESH));
    assign cmp1_result    = cmp1_drive;
    assign edge_input_pin = pin_drive;
endmodule

// *** verif/ctu_charge_timer_bench.sv ***
// bench for the charge timer edge control block
// assumes ctu_pkg and ctu_analog_model compiled first
`timescale 1ns/1ns
module ctu_charge_timer_bench
    import ctu_pkg::*;
;
    localparam logic [31:0] C_BASE = 32'hC0C0_8800;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        idle_mode = 1'b0;
    logic [3:0]  be = 4'hF;
    logic [18:0] src = 19'h0;
    logic [12:0] pins;
    logic        cmp1, cmp2, cs_on, gnd, trig, dly;
    logic [5:0]  trim;
    logic [1:0]  rng;
    logic [5:0]  tv [4] = '{6'h1F, 6'h21, 6'h00, 6'h3F};
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #4 clock = ~clock;

    ctu_charge_timer dut (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
        .idle_mode(idle_mode), .first_tick_event(src[13]), .compare1_event(src[14]),
        .capture1_event(src[15]), .capture2_event(src[16]), .capture3_event(src[17]),
        .edge_input_pin(pins), .cmp1_result(cmp1), .cmp2_result(cmp2), .current_source_on(cs_on),
        .source_ground(gnd), .trigger_out(trig), .delay_gen_active(dly), .current_trim(trim),
        .current_range(rng));
    ctu_analog_model far (.clock(clock), .nrst(nrst), .current_source_on(cs_on), .source_ground(gnd),
        .current_range(rng), .pin_drive(src[12:0]), .cmp1_drive(src[18]), .edge_input_pin(pins),
        .cmp1_result(cmp1), .cmp2_result(cmp2));

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    endtask
    // two extra edges: derived outputs land one cycle after the write
    task automatic wr(input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, CTU_CTRL_ADDR, d, q);
        repeat (2) @(posedge clock);
    endtask
    task automatic rd(output logic [31:0] q);
        bus(1'b0, CTU_CTRL_ADDR, 32'h0, q);
    endtask
    // held 4 cycles so synchronised pins see it too
    task automatic pulse(input int k);
        @(posedge clock);
        src[k] <= 1'b1;
        repeat (4) @(posedge clock);
        src[k] <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    function automatic logic [31:0] sel(input logic [3:0] a, input logic [3:0] b);
        return (32'(a) << CTU_E1_SEL_LO) | (32'(b) << CTU_E2_SEL_LO);
    endfunction
    function automatic int idx(input bit s, input logic [3:0] c);
        case (c)
            4'h0: return 13;
            4'h1: return 14;
            4'h2: return 1;
            4'h3: return 0;
            4'hD: return 18;
            default: if (!s) return (c <= 4'h9) ? int'(c) - 2 : int'(c) + 5;
                     else return (c <= 4'h8) ? int'(c) + 4 : int'(c) + 6;
        endcase
    endfunction
    // other edge on reserved select: constant low, no rising edge
    task automatic edge_try(input bit s, input logic [3:0] c);
        logic [31:0] q;
        int b;
        b = s ? CTU_E2_SEEN : CTU_E1_SEEN;
        wr(C_BASE | (s ? sel(4'hF, c) : sel(c, 4'hF)));
        rd(q);
        chk("quiet flag", 32'h0, q[b]);
        pulse(idx(s, c));
        rd(q);
        chk("edge flag", 32'h1, q[b]);
        chk("source on", 32'h1, cs_on);
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict;
        end
    end

    initial begin
        logic [31:0] q;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rd(q);
        chk("ctrl reset", CTU_CTRL_RESET, q);
        chk("outs reset", 32'h0, {cs_on, gnd, trig, dly, trim, rng});
        wr(32'hFFFF_FFFF);
        rd(q);
        chk("ctrl ones", 32'hFFFC_BFFF, q);
        chk("ground", 32'h1, gnd);
        chk("delay gen", 32'h1, dly);
        chk("trigger", 32'h1, trig);
        chk("both flags", 32'h0, cs_on);
        bus(1'b0, 4'h4, 32'h0, q);
        chk("unmapped rd", 32'h0, q);
        bus(1'b1, 4'h8, 32'h0, q);
        rd(q);
        chk("unmapped wr", 32'hFFFC_BFFF, q);
        idle_mode <= 1'b1;
        repeat (3) @(posedge clock);
        chk("idle stop", 32'h0, dly);
        wr(32'hFFFF_DFFF);
        chk("idle run", 32'h1, dly);
        idle_mode <= 1'b0;
        wr(32'hFFFF_DEFF);
        chk("trigger off", 32'h0, trig);
        for (int i = 0; i < 4; i++) begin
            wr({24'h0, tv[i], 2'(i)});
            chk("trim", 32'(tv[i]), 32'(trim));
            chk("range", 32'(i), 32'(rng));
        end
        be <= 4'h1;
        wr(32'hFFFF_FF01);
        be <= 4'hF;
        rd(q);
        chk("byte lane", 32'h0000_0001, q);
        $display("register test done");
        for (int c = 0; c < 14; c++) begin
            edge_try(1'b0, 4'(c));
            if (c != 12) edge_try(1'b1, 4'(c));
        end
        wr(C_BASE | sel(4'hF, CTU_SEL2_BUSCLK));
        rd(q);
        chk("bus clock", 32'h1, q[CTU_E2_SEEN]);
        $display("source test done");
        wr(32'h0000_8800 | sel(4'hF, 4'hF));
        rd(q);
        chk("level low", 32'h3, q[25:24]);
        // a level hit in the closing cycle wins over the clear, so clear again
        wr(32'h0000_8000 | sel(4'hF, 4'hF));
        wr(32'h0000_8000 | sel(4'hF, 4'hF));
        rd(q);
        chk("gate closed", 32'h0, q[25:24]);
        wr(32'h8080_8800 | sel(4'h3, 4'hF));
        @(posedge clock);
        src[0] <= 1'b1;
        repeat (5) @(posedge clock);
        rd(q);
        chk("rise ignored", 32'h0, q[24]);
        src[0] <= 1'b0;
        repeat (5) @(posedge clock);
        rd(q);
        chk("fall seen", 32'h1, q[24]);
        wr(C_BASE | 32'h400 | sel(4'h3, 4'h2));
        pulse(1);
        rd(q);
        chk("order held", 32'h0, q[25:24]);
        pulse(0);
        pulse(1);
        rd(q);
        chk("order met", 32'h3, q[25:24]);
        wr((C_BASE & 32'hFFFF_7FFF) | sel(4'h3, 4'hF));
        pulse(0);
        rd(q);
        chk("unit off", 32'h0, q[24]);
        wr(C_BASE | 32'h2000 | sel(4'h3, 4'hF));
        idle_mode <= 1'b1;
        pulse(0);
        rd(q);
        chk("idle edge", 32'h0, q[24]);
        idle_mode <= 1'b0;
        $display("edge control test done");
        wr(32'h0000_8200);
        chk("ground out", 32'h1, gnd);
        wr(C_BASE | 32'h1101 | sel(4'h3, CTU_SEL_CMP2));
        chk("delay gen", 32'h1, dly);
        chk("trig idle", 32'h0, trig);
        pulse(0);
        chk("charging", 32'h1, cs_on);
        for (int n = 0; n < 200 && trig !== 1'b1; n++) @(posedge clock);
        chk("trigger", 32'h1, trig);
        chk("source off", 32'h0, cs_on);
        rd(q);
        chk("both seen", 32'h3, q[25:24]);
        $display("delay test done");
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(q);
        chk("ctrl re-reset", CTU_CTRL_RESET, q);
        chk("outs re-reset", 32'h0, {cs_on, gnd, trig, dly, trim, rng});
        $display("reset test done");
        print_verdict;
    end
endmodule
